// >>> common/cilr_pkg.sv
// Constants, register map and source codes for the camera I/O line routing.
// Assumes a 32-bit classic Wishbone slave with byte addressing.
package cilr_pkg;

   // ==========================================================
   // Bus geometry
   localparam int WB_AW = 8;
   localparam int WB_DW = 32;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] OUTCFG_OFS   = 8'h04;
   localparam logic [7:0] LINESEL_OFS  = 8'h08;
   localparam logic [7:0] LINESTAT_OFS = 8'h0C;
   localparam logic [7:0] LINEALL_OFS  = 8'h10;

   // ==========================================================
   // Field positions
   localparam int CTRL_TRIG_BIT   = 0;
   localparam int CTRL_LEGACY_BIT = 1;
   localparam int OUTCFG_SRC_LSB  = 0;
   localparam int OUTCFG_INV_BIT  = 4;
   localparam int OUTCFG_USER_BIT = 8;
   localparam int LINE_IN_IDX     = 0;
   localparam int LINE_OUT_IDX    = 1;

   // ==========================================================
   // Output source codes
   typedef enum logic [2:0] {
      SRC_TRIG_WAIT  = 3'h0,
      SRC_TRIG_READY = 3'h1,
      SRC_EXPOSURE   = 3'h2,
      SRC_TIMER1     = 3'h3,
      SRC_USER       = 3'h4
   } cilr_src_e;

   // ==========================================================
   // Values after reset and counts
   localparam logic      TRIG_ASSIGN_RST = 1'b1;
   localparam logic      LEGACY_RST      = 1'b0;
   localparam cilr_src_e SRC_RST         = SRC_EXPOSURE;
   localparam logic      INV_RST         = 1'b0;
   localparam logic      USER_VAL_RST    = 1'b0;
   localparam logic      LINE_SEL_RST    = 1'b0;
   localparam int        SYNC_DEPTH      = 2;

endpackage

// >>> common/cilr_sel_if.sv
// Carrier between the routing core and the output line driver.
// Assumes both ends share ref_clk; no timing of its own.
`timescale 1ns/100ps
interface cilr_sel_if;
   import cilr_pkg::*;
   cilr_src_e src;
   logic      inv;
   logic      user_val;
   logic      legacy;
   logic      trig_wait;
   logic      trig_ready;
   logic      exp_act;
   logic      timer1;
   logic      line_drive;

   modport ctl (
      output src, inv, user_val, legacy,
      output trig_wait, trig_ready, exp_act, timer1,
      input  line_drive
   );
   modport drv (
      input  src, inv, user_val, legacy,
      input  trig_wait, trig_ready, exp_act, timer1,
      output line_drive
   );
endinterface

// >>> verilog/cilr_out_drive.sv
// Output line driver: source selection, inversion, registered drive.
// Assumes all inputs are synchronous to ref_clk.
`timescale 1ns/100ps
module cilr_out_drive (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // Selection and sources
   cilr_sel_if.drv   sel
);
   import cilr_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic drive;
   } cilr_drv_s;

   cilr_drv_s state_reg;
   cilr_drv_s state_next;
   logic      pre_inv;

   always_comb begin
      // Trigger wait exists only in standard mode.
      unique case (sel.src)
         SRC_TRIG_WAIT:  pre_inv = sel.trig_wait & ~sel.legacy;
         SRC_TRIG_READY: pre_inv = sel.trig_ready;
         SRC_EXPOSURE:   pre_inv = sel.exp_act;
         SRC_TIMER1:     pre_inv = sel.timer1;
         SRC_USER:       pre_inv = sel.user_val;
         default:        pre_inv = 1'b0;
      endcase
      state_next       = state_reg;
      state_next.drive = pre_inv ^ sel.inv;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sel.line_drive = state_reg.drive;

endmodule

// >>> verilog/cilr_top.sv
// Camera I/O line routing core with a classic Wishbone register slave.
// Assumes one clock, ref_clk at 200 MHz, and an asynchronous input line.
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module cilr_top #(
   parameter int SYNC_STAGES = cilr_pkg::SYNC_DEPTH
) (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        rstn,
   // Wishbone slave
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [cilr_pkg::WB_AW-1:0]  wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [cilr_pkg::WB_DW-1:0]  wb_dat_i,
   output logic      [cilr_pkg::WB_DW-1:0]  wb_dat_o,
   output logic                             wb_ack_o,
   // Physical lines
   input  wire logic                        input_line,
   output logic                             out_transistor_on,
   // Acquisition side
   input  wire logic                        sensor_exposing,
   input  wire logic                        trig_wait_in,
   input  wire logic                        trig_ready_in,
   input  wire logic                        timer1_in,
   output logic                             frame_start_trigger,
   output logic                             acq_start_trigger,
   output logic                             user_input_level,
   output logic                             exposure_active_flag
);
   import cilr_pkg::*;

   // ==========================================================
   // Parameter check
   if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2");
   end

   // ==========================================================
   // Bus states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } cilr_bus_e;

   // ==========================================================
   // State
   typedef struct packed {
      cilr_bus_e               bus;
      logic                    ack;
      logic [WB_DW-1:0]        rdata;
      logic                    trig_assign;
      logic                    legacy;
      logic                    line_sel;
      cilr_src_e               src;
      logic                    inv;
      logic                    user_val;
      logic [SYNC_STAGES-1:0]  sync;
      logic                    exp_flag;
      logic                    frame_trig;
      logic                    acq_trig;
      logic                    user_in;
   } cilr_top_s;

   cilr_top_s        state_reg;
   cilr_top_s        state_next;
   cilr_sel_if       sel_bus ();
   logic             line_level;
   logic             req;
   logic             ext_trig;
   logic [WB_DW-1:0] rd_mux;
   logic [WB_DW-1:0] ctrl_word;
   logic [WB_DW-1:0] outcfg_word;
   logic [1:0]       lines_all;

   // The last synchroniser stage is the only one read outside the chain.
   assign line_level = state_reg.sync[SYNC_STAGES-1];
   assign req        = wb_cyc_i & wb_stb_i;

   // ==========================================================
   // Readback words
   always_comb begin
      ctrl_word                     = '0;
      ctrl_word[CTRL_TRIG_BIT]      = state_reg.trig_assign;
      ctrl_word[CTRL_LEGACY_BIT]    = state_reg.legacy;
      outcfg_word                   = '0;
      outcfg_word[OUTCFG_SRC_LSB +: 3] = state_reg.src;
      outcfg_word[OUTCFG_INV_BIT]   = state_reg.inv;
      outcfg_word[OUTCFG_USER_BIT]  = state_reg.user_val;
      lines_all                     = '0;
      lines_all[LINE_IN_IDX]        = line_level;
      lines_all[LINE_OUT_IDX]       = sel_bus.line_drive;
      unique case (wb_adr_i)
         CTRL_OFS:     rd_mux = ctrl_word;
         OUTCFG_OFS:   rd_mux = outcfg_word;
         LINESEL_OFS:  rd_mux = {{(WB_DW-1){1'b0}}, state_reg.line_sel};
         LINESTAT_OFS: rd_mux = {{(WB_DW-1){1'b0}},
                                 lines_all[state_reg.line_sel]};
         LINEALL_OFS:  rd_mux = {{(WB_DW-2){1'b0}}, lines_all};
         default:      rd_mux = '0;
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      state_next = state_reg;

      // Synchroniser chain for the asynchronous input line.
      state_next.sync = {state_reg.sync[SYNC_STAGES-2:0],
                         input_line};

      // Exposure flag follows the sensor with one register of delay.
      state_next.exp_flag = sensor_exposing;

      // Trigger routing: a trigger-assigned line feeds exactly one trigger by mode.
      ext_trig = line_level & state_reg.trig_assign;
      state_next.frame_trig = ext_trig & ~state_reg.legacy;
      state_next.acq_trig   = ext_trig & state_reg.legacy;

      // A trigger-assigned line never shows up as a user input.
      state_next.user_in = line_level & ~state_reg.trig_assign;

      // Bus slave: one ack per request, dropped the next cycle.
      unique case (state_reg.bus)
         BUS_IDLE: begin
            state_next.ack = 1'b0;
            if (req) begin
               state_next.bus   = BUS_ACK;
               state_next.ack   = 1'b1;
               state_next.rdata = wb_we_i ? '0 : rd_mux;
               if (wb_we_i) begin
                  unique case (wb_adr_i)
                     CTRL_OFS: begin
                        if (wb_sel_i[0]) begin
                           state_next.trig_assign =
                              wb_dat_i[CTRL_TRIG_BIT];
                           state_next.legacy =
                              wb_dat_i[CTRL_LEGACY_BIT];
                        end
                     end
                     OUTCFG_OFS: begin
                        if (wb_sel_i[0]) begin
                           state_next.src = cilr_src_e'(
                              wb_dat_i[OUTCFG_SRC_LSB +: 3]);
                           state_next.inv =
                              wb_dat_i[OUTCFG_INV_BIT];
                        end
                        if (wb_sel_i[1]) begin
                           state_next.user_val =
                              wb_dat_i[OUTCFG_USER_BIT];
                        end
                     end
                     LINESEL_OFS: begin
                        if (wb_sel_i[0]) begin
                           state_next.line_sel = wb_dat_i[0];
                        end
                     end
                     default: begin
                        state_next.line_sel = state_reg.line_sel;
                     end
                  endcase
               end
            end
         end
         BUS_ACK: begin
            // Master releases after this edge; no second ack.
            state_next.bus   = BUS_IDLE;
            state_next.ack   = 1'b0;
            state_next.rdata = '0;
         end
         default: begin
            state_next.bus   = BUS_IDLE;
            state_next.ack   = 1'b0;
            state_next.rdata = '0;
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg             <= '0;
         state_reg.bus         <= BUS_IDLE;
         state_reg.trig_assign <= TRIG_ASSIGN_RST;
         state_reg.legacy      <= LEGACY_RST;
         state_reg.line_sel    <= LINE_SEL_RST;
         state_reg.src         <= SRC_RST;
         state_reg.inv         <= INV_RST;
         state_reg.user_val    <= USER_VAL_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Output line driver
   assign sel_bus.src        = state_reg.src;
   assign sel_bus.inv        = state_reg.inv;
   assign sel_bus.user_val   = state_reg.user_val;
   assign sel_bus.legacy     = state_reg.legacy;
   assign sel_bus.trig_wait  = trig_wait_in;
   assign sel_bus.trig_ready = trig_ready_in;
   assign sel_bus.exp_act    = state_reg.exp_flag;
   assign sel_bus.timer1     = timer1_in;

   cilr_out_drive u_out (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .sel     (sel_bus.drv)
   );

   // ==========================================================
   // Outputs
   assign wb_dat_o             = state_reg.rdata;
   assign wb_ack_o             = state_reg.ack;
   assign out_transistor_on    = sel_bus.line_drive;
   assign frame_start_trigger  = state_reg.frame_trig;
   assign acq_start_trigger    = state_reg.acq_trig;
   assign user_input_level     = state_reg.user_in;
   assign exposure_active_flag = state_reg.exp_flag;

endmodule

// >>> bench/cilr_top_props.sv
// Checker for the camera I/O line routing core.
// Assumes it sees only the core's ports, bound from the bench top.
`timescale 1ns/100ps
module cilr_top_props #(
   parameter int SYNC_STAGES = 2
) (
   // Clock and reset
   input wire logic                       ref_clk,
   input wire logic                       rstn,
   // Wishbone
   input wire logic                       wb_cyc_i,
   input wire logic                       wb_stb_i,
   input wire logic                       wb_we_i,
   input wire logic [cilr_pkg::WB_AW-1:0] wb_adr_i,
   input wire logic [3:0]                 wb_sel_i,
   input wire logic [cilr_pkg::WB_DW-1:0] wb_dat_i,
   input wire logic [cilr_pkg::WB_DW-1:0] wb_dat_o,
   input wire logic                       wb_ack_o,
   // Lines and acquisition side
   input wire logic                       input_line,
   input wire logic                       out_transistor_on,
   input wire logic                       sensor_exposing,
   input wire logic                       trig_wait_in,
   input wire logic                       trig_ready_in,
   input wire logic                       timer1_in,
   input wire logic                       frame_start_trigger,
   input wire logic                       acq_start_trigger,
   input wire logic                       user_input_level,
   input wire logic                       exposure_active_flag
);
   import cilr_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // Sequences
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   // Config writes and source moves both disturb the pin, so both wait.
   sequence s_quiet;
      (!wb_cyc_i && $stable(sensor_exposing) && $stable(trig_wait_in)
       && $stable(trig_ready_in) && $stable(timer1_in))[*3];
   endsequence
   // ==========================================================
   // Assertions
   a_ack_pulse: assert property (s_req |=> s_pulse)
      else $error("ack not a single pulse after request");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == '0)
      else $error("read data outside ack");
   a_expo_copy: assert property (1'b1 |=>
      exposure_active_flag == $past(sensor_exposing))
      else $error("exposure flag not a copy of sensor");
   a_trig_mutex: assert property
      (!(frame_start_trigger && acq_start_trigger))
      else $error("both trigger roles active");
   a_user_excl: assert property (user_input_level |->
      !frame_start_trigger && !acq_start_trigger)
      else $error("user input while trigger routed");
   a_sync_delay: assert property (frame_start_trigger ||
      acq_start_trigger || user_input_level |->
      $past(input_line, SYNC_STAGES + 1))
      else $error("input line level arrived too early");
   a_out_quiet: assert property (s_quiet |-> $stable(out_transistor_on))
      else $error("output line moved without cause");
endmodule

// >>> bench/cilr_ext_dev.sv
// Far-side equipment: trigger source on the input line, output monitor.
// Assumes level_req changes just after a rising edge of ref_clk.
`timescale 1ns/100ps
module cilr_ext_dev (
   // Clock
   input wire logic        ref_clk,
   // Control from bench
   input wire logic        level_req,
   input wire logic [3:0]  lag,
   // Lines
   input wire logic        out_transistor_on,
   output logic            input_line,
   output logic [7:0]      out_rises
);
   logic [15:0] hist = 16'h0000;
   logic        out_d = 1'b0;
   initial input_line = 1'b0;
   initial out_rises = 8'h00;
   // The line moves off the clock edge, as an opto-coupled source would.
   always @(posedge ref_clk) begin
      hist <= {hist[14:0], level_req};
      input_line <= #1.7 (lag == 4'h0) ? level_req : hist[lag - 4'h1];
      out_d <= out_transistor_on;
      if (out_transistor_on && !out_d) begin
         out_rises <= out_rises + 8'h01;
      end
   end
endmodule

// >>> bench/test_cilr_top.sv
// Self-checking bench for the camera I/O line routing core.
// Assumes the checker and far-side model files are compiled before it.
`timescale 1ns/100ps
module test_cilr_top;
   import cilr_pkg::*;
   logic ref_clk = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0]  wb_adr_i = 8'h00, rises;
   logic [3:0]  wb_sel_i = 4'h0, lag = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, input_line, out_transistor_on, lvl = 0;
   logic sensor_exposing = 0, trig_wait_in = 0, trig_ready_in = 0;
   logic timer1_in = 0, frame_start_trigger, acq_start_trigger;
   logic user_input_level, exposure_active_flag;
   int   err_total = 0, n_tests = 0;
   always #2.5 ref_clk = ~ref_clk;
   cilr_top #(.SYNC_STAGES(2)) DUT (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .input_line, .out_transistor_on, .sensor_exposing, .trig_wait_in,
      .trig_ready_in, .timer1_in, .frame_start_trigger, .acq_start_trigger,
      .user_input_level, .exposure_active_flag);
   cilr_ext_dev u_ext (.ref_clk, .level_req(lvl), .lag, .out_transistor_on,
      .input_line, .out_rises(rises));
   // ==========================================================
   // Common tasks
   task finish_test;
      if (err_total == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] s);
      int k;
      k = 0;
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge ref_clk);
         k++;
      end while (wb_ack_o !== 1'b1);
      // Ack follows the taking edge by one cycle, so two edges pass here.
      chk(32'(k), 32'h2, "ack latency");
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hF);
      chk(rd & m, e, "register read");
   endtask
   // ==========================================================
   // Scenarios
   task t_reset;
      rdc(CTRL_OFS, 32'h3, 32'h1);
      rdc(OUTCFG_OFS, 32'h117, 32'h2);
      rdc(8'h14, 32'hFFFFFFFF, 32'h0);
      wb(1'b1, OUTCFG_OFS, 32'h4, 4'h0);
      rdc(OUTCFG_OFS, 32'h117, 32'h2);
   endtask
   task t_trigger;
      lvl <= 1'b1;
      tick(6);
      chk({frame_start_trigger, acq_start_trigger, user_input_level},
          32'h4, "frame start role");
      rdc(LINEALL_OFS, 32'h1, 32'h1);
      wr(CTRL_OFS, 32'h3);
      tick(4);
      chk({frame_start_trigger, acq_start_trigger}, 32'h1, "legacy");
      wr(CTRL_OFS, 32'h0);
      tick(4);
      chk({frame_start_trigger, acq_start_trigger, user_input_level},
          32'h1, "user role");
      wr(LINESEL_OFS, 32'h0);
      rdc(LINESTAT_OFS, 32'h1, 32'h1);
      lvl <= 1'b0;
      tick(4);
      chk({31'h0, user_input_level}, 32'h1, "sync too fast");
      tick(1);
      chk({31'h0, user_input_level}, 32'h0, "sync too slow");
      lag <= 4'h5;
      lvl <= 1'b1;
      tick(12);
      chk({31'h0, user_input_level}, 32'h1, "slow source");
      wr(CTRL_OFS, 32'h1);
   endtask
   task t_expo;
      sensor_exposing <= 1'b1;
      tick(2);
      chk({exposure_active_flag, out_transistor_on}, 32'h2, "flag");
      tick(1);
      chk({31'h0, out_transistor_on}, 32'h1, "expo pin");
      sensor_exposing <= 1'b0;
      tick(3);
      chk({exposure_active_flag, out_transistor_on}, 32'h0, "off");
      chk({24'h0, rises}, 32'h1, "pin rises");
   endtask
   task t_sources;
      for (int c = 0; c < 4; c++) begin
         wr(OUTCFG_OFS, 32'(c));
         {timer1_in, sensor_exposing, trig_ready_in, trig_wait_in} <= 4'h1 << c;
         tick(4);
         chk({31'h0, out_transistor_on}, 32'h1, "src on");
         {timer1_in, sensor_exposing, trig_ready_in, trig_wait_in} <=
            ~(4'h1 << c);
         tick(4);
         chk({31'h0, out_transistor_on}, 32'h0, "src off");
         wr(OUTCFG_OFS, 32'(c) | 32'h10);
         tick(3);
         chk({31'h0, out_transistor_on}, 32'h1, "inverted");
      end
      {timer1_in, sensor_exposing, trig_ready_in, trig_wait_in} <= 4'h0;
      wr(OUTCFG_OFS, 32'h104);
      tick(3);
      chk({31'h0, out_transistor_on}, 32'h1, "user one");
      wr(LINESEL_OFS, 32'h1);
      rdc(LINESEL_OFS, 32'h1, 32'h1);
      rdc(LINESTAT_OFS, 32'h1, 32'h1);
      wr(OUTCFG_OFS, 32'h114);
      tick(3);
      chk({31'h0, out_transistor_on}, 32'h0, "user inverted");
      rdc(OUTCFG_OFS, 32'h117, 32'h114);
      rdc(LINEALL_OFS, 32'h2, 32'h0);
      // An unused source code must not leak the user value onto the pin.
      wr(OUTCFG_OFS, 32'h105);
      tick(3);
      chk({31'h0, out_transistor_on}, 32'h0, "unused source");
      rdc(OUTCFG_OFS, 32'h117, 32'h105);
      wr(CTRL_OFS, 32'h3);
      wr(OUTCFG_OFS, 32'h0);
      trig_wait_in <= 1'b1;
      tick(4);
      chk({31'h0, out_transistor_on}, 32'h0, "wait in legacy");
      wr(CTRL_OFS, 32'h1);
   endtask
   task t_rerst;
      // A reset in mid-run must bring back the default routing.
      rstn <= 1'b0;
      tick(3);
      chk({26'h0, frame_start_trigger, acq_start_trigger, user_input_level,
           exposure_active_flag, out_transistor_on, wb_ack_o}, 32'h0,
          "outputs in reset");
      rstn <= 1'b1;
      t_reset;
      chk({frame_start_trigger, acq_start_trigger, out_transistor_on},
          32'h4, "roles after reset");
   endtask
   // ==========================================================
   // Sequence and watchdog
   initial begin
      tick(3);
      rstn <= 1'b1;
      t_reset;
      t_trigger;
      t_expo;
      t_sources;
      t_rerst;
      finish_test;
   end
   initial begin
      tick(5000);
      err_total++;
      finish_test;
   end
endmodule
bind cilr_top cilr_top_props #(.SYNC_STAGES(SYNC_STAGES)) u_props (.ref_clk,
   .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_dat_o, .wb_ack_o, .input_line, .out_transistor_on, .sensor_exposing,
   .trig_wait_in, .trig_ready_in, .timer1_in, .frame_start_trigger,
   .acq_start_trigger, .user_input_level, .exposure_active_flag);
